// ===== common/ibc_pkg.sv
/*
  ibc_pkg: constants, register offsets and carrier structs for the
  ingress basic frame classifier.
  assumes: one aclk domain, 32-bit axi4-lite register access.
*/
package ibc_pkg;

  // ----------------------------------------------------------------
  // frame constants
  // ----------------------------------------------------------------
  localparam logic [15:0] TPID_CTAG = 16'h8100;
  localparam logic [15:0] TPID_STAG = 16'h88a8;
  localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
  localparam logic [15:0] ETYPE_IPV6 = 16'h86dd;
  localparam logic [15:0] ETYPE_RAF = 16'h8880;
  localparam logic [15:0] RAF_PROTO_ID = 16'h0004;
  localparam logic [39:0] MAC_BRIDGE_PFX = 40'h0180c20000;
  localparam logic [24:0] MAC_IPV4MC_PFX = 25'h0200bc; // 01005e, bit23=0
  localparam logic [15:0] MAC_IPV6MC_PFX = 16'h3333;
  localparam logic [7:0] IP_PROTO_IGMP = 8'h02;
  localparam logic [7:0] IP6_NH_HOPBYHOP = 8'h00;
  localparam logic [23:0] IPV4_LOCAL_PFX = 24'he00000;
  localparam logic [31:0] MLD_RTR_ALERT = 32'h05020000;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PORT_VLAN = 8'h00;
  localparam logic [7:0] REG_CUSTOM_TPID = 8'h04;
  localparam logic [7:0] REG_PORT_TIMING = 8'h08;
  localparam logic [7:0] REG_AGGR_SRC = 8'h0c;
  localparam logic [7:0] REG_CPU_FWD = 8'h10;
  localparam logic [7:0] REG_BPDU_ACT = 8'h14;
  localparam logic [7:0] REG_GARP_ACT = 8'h18;
  localparam logic [7:0] REG_CCM_ACT = 8'h1c;
  localparam logic [7:0] REG_CPUQ = 8'h20;
  localparam logic [7:0] REG_RAF_VLAN = 8'h24;
  localparam logic [7:0] REG_RAF_VALUE = 8'h28;
  localparam logic [7:0] REG_RAF_MASK = 8'h2c;
  localparam logic [7:0] REG_STATUS = 8'h30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // port_vlan_config: vid[11:0] dei[12] pcp[15:13] stype[16]
  //   inner_tag_select[17] egress_pop_count[19:18]
  localparam int PVC_DEI = 12;
  localparam int PVC_PCP = 13;
  localparam int PVC_TYPE = 16;
  localparam int PVC_INNER = 17;
  localparam int PVC_POP = 18;
  localparam int PTD_QOS_PCP = 0;
  // aggregation_source_config bits
  localparam int AGG_DMAC = 0;
  localparam int AGG_SMAC = 1;
  localparam int AGG_FLOW = 2;
  localparam int AGG_IP = 3;
  localparam int AGG_L4 = 4;
  localparam int AGG_RAND = 5;
  // port_cpu_forward_config bits
  localparam int CFW_IGMP = 0;
  localparam int CFW_MLD = 1;
  localparam int CFW_IPMC = 2;
  localparam int CFW_ALLBR = 3; // two bits, action code
  localparam int CFW_RAF = 5;
  // cpu queue config: 3-bit queue numbers
  localparam int CQ_IGMP = 0;
  localparam int CQ_MLD = 3;
  localparam int CQ_IPMC = 6;
  localparam int CQ_RAF = 9;
  localparam int CQ_BPDU = 12;
  localparam int CQ_GARP = 15;
  localparam int CQ_CCM = 18;
  localparam int CQ_ALLBR = 21;
  localparam int RAV_AWARE = 12;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_PORT_VLAN = 32'h0000_0001;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    IBC_ACT_NONE = 2'h0,
    IBC_ACT_COPY = 2'h1,
    IBC_ACT_REDIR = 2'h2,
    IBC_ACT_DISCARD = 2'h3
  } ibc_act_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [1:0] tag_cnt;
    logic [15:0] tpid0;
    logic [15:0] tci0;
    logic [15:0] tpid1;
    logic [15:0] tci1;
    logic [15:0] etype;
    logic [15:0] proto_id;
    logic [31:0] raf_hdr;
    logic [7:0] ip_proto;
    logic [31:0] sip;
    logic [31:0] dip;
    logic [19:0] flow_label;
    logic [31:0] ip6_hbh_opt;
    logic l4_valid;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [2:0] qos;
  } ibc_frame_t;

  typedef struct packed {
    logic stag;
    logic [2:0] pcp;
    logic dei;
    logic [11:0] vid;
    logic prio_tag;
  } ibc_tag_t;

  typedef struct packed {
    ibc_tag_t tag;
    logic [1:0] pop_cnt;
    logic [3:0] aggr;
    logic [7:0] cpuq_mask;
    logic redirect;
    logic discard;
  } ibc_result_t;

endpackage

// ===== rtl/ibc_classifier.sv
/*
  ibc_classifier: tag header, pop count, aggregation code and
  cpu forwarding per frame; axi4-lite configuration.
  assumes: one parsed frame per fr_valid pulse; no back-pressure
  on res_valid.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
// How it works
// - result holds pcp, dei, vid, tag type
// - c-tag 8100; s-tag 88a8 or custom tpid
// - zero vid in a frame tag means priority tag, else vlan; port default never priority
// - frame tag applies, else port default
// - inner select uses inner of two tags
// - pop count clamped to tags present
// - qos-as-pcp replaces pcp with qos class
// - low 12 dmac/smac bits, separately enabled
// - whole 20-bit flow label when enabled
// - low 8 ip address and port bits
// - random option replaces frame information
// - contributions xored into 4-bit code
// - cpu events ored into final queue mask
// - redirect sets res.redirect; copy only sets a queue bit
// - bridge range and all-bridges configurable actions
// - garp and ccm range configurable actions
// - igmp redirected; 224.0.0.x non-igmp copied
// - mld hop-by-hop router alert redirected
// - access filter vlan check rules
// - access filter etype 8880, id 0004
// - masked 32-bit header compare
// - all checks pass: redirect to queue
`timescale 1ns/1ps
module ibc_classifier
  import ibc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // parsed frame in
  input wire logic fr_valid,
  input wire ibc_frame_t fr_info,
  input wire logic [7:0] ext_cpuq_mask,
  // classification out
  output logic res_valid,
  output ibc_result_t res
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] port_vlan_config;
  logic [15:0] custom_tpid_config;
  logic [31:0] port_timing_delay_config;
  logic [31:0] aggregation_source_config;
  logic [31:0] port_cpu_forward_config;
  logic [31:0] bpdu_act;
  logic [31:0] garp_act;
  logic [31:0] ccm_act;
  logic [31:0] cpuq_config;
  logic [31:0] raf_vlan;
  logic [31:0] rafilter_header_value;
  logic [31:0] rafilter_header_mask;
  logic [15:0] frame_count;
  logic [15:0] lfsr;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] tpid_wr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign tpid_wr = merge({16'h0000, custom_tpid_config}, w_data, w_strb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > REG_RAF_MASK || aw_addr[1:0] != 2'b00)
                       ? 2'b10 : 2'b00;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_vlan_config <= RST_PORT_VLAN;
      custom_tpid_config <= RST_ZERO[15:0];
      port_timing_delay_config <= RST_ZERO;
      aggregation_source_config <= RST_ZERO;
      port_cpu_forward_config <= RST_ZERO;
      bpdu_act <= RST_ZERO;
      garp_act <= RST_ZERO;
      ccm_act <= RST_ZERO;
      cpuq_config <= RST_ZERO;
      raf_vlan <= RST_ZERO;
      rafilter_header_value <= RST_ZERO;
      rafilter_header_mask <= RST_ZERO;
    end
    else if (do_write)
    begin
      case (aw_addr)
        REG_PORT_VLAN: port_vlan_config <=
          merge(port_vlan_config, w_data, w_strb);
        REG_CUSTOM_TPID: custom_tpid_config <= tpid_wr[15:0];
        REG_PORT_TIMING: port_timing_delay_config <=
          merge(port_timing_delay_config, w_data, w_strb);
        REG_AGGR_SRC: aggregation_source_config <=
          merge(aggregation_source_config, w_data, w_strb);
        REG_CPU_FWD: port_cpu_forward_config <=
          merge(port_cpu_forward_config, w_data, w_strb);
        REG_BPDU_ACT: bpdu_act <= merge(bpdu_act, w_data, w_strb);
        REG_GARP_ACT: garp_act <= merge(garp_act, w_data, w_strb);
        REG_CCM_ACT: ccm_act <= merge(ccm_act, w_data, w_strb);
        REG_CPUQ: cpuq_config <= merge(cpuq_config, w_data, w_strb);
        REG_RAF_VLAN: raf_vlan <= merge(raf_vlan, w_data, w_strb);
        REG_RAF_VALUE: rafilter_header_value <=
          merge(rafilter_header_value, w_data, w_strb);
        REG_RAF_MASK: rafilter_header_mask <=
          merge(rafilter_header_mask, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          REG_PORT_VLAN: s_axi_rdata <= port_vlan_config;
          REG_CUSTOM_TPID: s_axi_rdata <= {16'h0000, custom_tpid_config};
          REG_PORT_TIMING: s_axi_rdata <= port_timing_delay_config;
          REG_AGGR_SRC: s_axi_rdata <= aggregation_source_config;
          REG_CPU_FWD: s_axi_rdata <= port_cpu_forward_config;
          REG_BPDU_ACT: s_axi_rdata <= bpdu_act;
          REG_GARP_ACT: s_axi_rdata <= garp_act;
          REG_CCM_ACT: s_axi_rdata <= ccm_act;
          REG_CPUQ: s_axi_rdata <= cpuq_config;
          REG_RAF_VLAN: s_axi_rdata <= raf_vlan;
          REG_RAF_VALUE: s_axi_rdata <= rafilter_header_value;
          REG_RAF_MASK: s_axi_rdata <= rafilter_header_mask;
          REG_STATUS: s_axi_rdata <= {16'h0000, frame_count};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // tag header and pop count
  // ----------------------------------------------------------------
  function automatic logic is_tag(input logic [15:0] tpid,
                                  input logic [15:0] custom);
    return tpid == TPID_CTAG || tpid == TPID_STAG || tpid == custom;
  endfunction

  function automatic logic [2:0] q3(input logic [31:0] w, input int pos);
    return w[pos +: 3];
  endfunction

  logic use_inner;
  logic [15:0] sel_tpid;
  logic [15:0] sel_tci;
  ibc_tag_t next_tag;
  logic [1:0] next_pop;

  always_comb
  begin
    use_inner = port_vlan_config[PVC_INNER] && fr_info.tag_cnt >= 2'd2;
    sel_tpid = use_inner ? fr_info.tpid1 : fr_info.tpid0;
    sel_tci = use_inner ? fr_info.tci1 : fr_info.tci0;
    if (fr_info.tag_cnt != 2'd0 && is_tag(sel_tpid, custom_tpid_config))
    begin
      next_tag.stag = sel_tpid != TPID_CTAG;
      next_tag.pcp = sel_tci[15:13];
      next_tag.dei = sel_tci[12];
      next_tag.vid = sel_tci[11:0];
      next_tag.prio_tag = sel_tci[11:0] == 12'h000;
    end
    else
    begin
      next_tag.stag = port_vlan_config[PVC_TYPE];
      next_tag.pcp = port_vlan_config[PVC_PCP +: 3];
      next_tag.dei = port_vlan_config[PVC_DEI];
      next_tag.vid = port_vlan_config[11:0];
      next_tag.prio_tag = 1'b0;
    end
    if (port_timing_delay_config[PTD_QOS_PCP])
      next_tag.pcp = fr_info.qos;
    next_pop = port_vlan_config[PVC_POP +: 2];
    if (next_pop > fr_info.tag_cnt)
      next_pop = fr_info.tag_cnt;
  end

  // ----------------------------------------------------------------
  // aggregation code
  // ----------------------------------------------------------------
  function automatic logic [3:0] fold8(input logic [7:0] v);
    return v[7:4] ^ v[3:0];
  endfunction

  logic is_ip4;
  logic is_ip6;
  logic [3:0] next_aggr;

  always_comb
  begin
    is_ip4 = fr_info.etype == ETYPE_IPV4;
    is_ip6 = fr_info.etype == ETYPE_IPV6;
    next_aggr = 4'h0;
    if (aggregation_source_config[AGG_RAND])
      next_aggr = lfsr[3:0];
    else
    begin
      if (aggregation_source_config[AGG_DMAC])
        next_aggr ^= fr_info.dmac[11:8] ^ fold8(fr_info.dmac[7:0]);
      if (aggregation_source_config[AGG_SMAC])
        next_aggr ^= fr_info.smac[11:8] ^ fold8(fr_info.smac[7:0]);
      if (aggregation_source_config[AGG_FLOW] && is_ip6)
        next_aggr ^= fr_info.flow_label[19:16] ^ fr_info.flow_label[15:12]
          ^ fold8(fr_info.flow_label[11:4]) ^ fr_info.flow_label[3:0];
      if (aggregation_source_config[AGG_IP] && is_ip4)
        next_aggr ^= fold8(fr_info.sip[7:0]) ^ fold8(fr_info.dip[7:0]);
      if (aggregation_source_config[AGG_L4] && (is_ip4 || is_ip6)
          && fr_info.l4_valid)
        next_aggr ^= fold8(fr_info.sport[7:0]) ^ fold8(fr_info.dport[7:0]);
    end
  end

  // ----------------------------------------------------------------
  // cpu forwarding
  // ----------------------------------------------------------------
  logic bridge_hit;
  logic [3:0] low_nib;
  logic [1:0] rsv_act;
  logic ipmc_mac;
  logic raf_vlan_ok;
  logic raf_hit;
  logic [7:0] next_mask;
  logic next_redir;
  logic next_discard;

  always_comb
  begin
    bridge_hit = fr_info.dmac[47:8] == MAC_BRIDGE_PFX;
    low_nib = fr_info.dmac[3:0];
    rsv_act = 2'b00;
    if (bridge_hit)
      case (fr_info.dmac[7:4])
        4'h0: rsv_act = bpdu_act[2*low_nib +: 2];
        4'h1: rsv_act = (low_nib == 4'h0)
                ? port_cpu_forward_config[CFW_ALLBR +: 2] : 2'b00;
        4'h2: rsv_act = garp_act[2*low_nib +: 2];
        4'h3: rsv_act = ccm_act[2*low_nib +: 2];
        default: rsv_act = 2'b00;
      endcase
    next_mask = 8'h00;
    next_redir = 1'b0;
    next_discard = rsv_act == IBC_ACT_DISCARD;
    if (rsv_act == IBC_ACT_COPY || rsv_act == IBC_ACT_REDIR)
    begin
      next_redir = rsv_act == IBC_ACT_REDIR;
      case (fr_info.dmac[7:4])
        4'h0: next_mask[q3(cpuq_config, CQ_BPDU)] = 1'b1;
        4'h1: next_mask[q3(cpuq_config, CQ_ALLBR)] = 1'b1;
        4'h2: next_mask[q3(cpuq_config, CQ_GARP)] = 1'b1;
        default: next_mask[q3(cpuq_config, CQ_CCM)] = 1'b1;
      endcase
    end
    ipmc_mac = fr_info.dmac[47:23] == MAC_IPV4MC_PFX && is_ip4;
    if (ipmc_mac && fr_info.ip_proto == IP_PROTO_IGMP
        && port_cpu_forward_config[CFW_IGMP])
    begin
      next_mask[q3(cpuq_config, CQ_IGMP)] = 1'b1;
      next_redir = 1'b1;
    end
    if (ipmc_mac && fr_info.ip_proto != IP_PROTO_IGMP
        && fr_info.dip[31:8] == IPV4_LOCAL_PFX
        && port_cpu_forward_config[CFW_IPMC])
      next_mask[q3(cpuq_config, CQ_IPMC)] = 1'b1;
    if (fr_info.dmac[47:32] == MAC_IPV6MC_PFX && is_ip6
        && fr_info.ip_proto == IP6_NH_HOPBYHOP
        && fr_info.ip6_hbh_opt == MLD_RTR_ALERT
        && port_cpu_forward_config[CFW_MLD])
    begin
      next_mask[q3(cpuq_config, CQ_MLD)] = 1'b1;
      next_redir = 1'b1;
    end
    if (raf_vlan[RAV_AWARE])
      raf_vlan_ok = fr_info.tag_cnt == 2'd1
                    && fr_info.tci0[11:0] == raf_vlan[11:0];
    else
      raf_vlan_ok = fr_info.tag_cnt == 2'd0;
    raf_hit = raf_vlan_ok && fr_info.etype == ETYPE_RAF
      && fr_info.proto_id == RAF_PROTO_ID
      && ((fr_info.raf_hdr ^ rafilter_header_value)
          & ~rafilter_header_mask) == 32'h0000_0000;
    if (raf_hit && port_cpu_forward_config[CFW_RAF])
    begin
      next_mask[q3(cpuq_config, CQ_RAF)] = 1'b1;
      next_redir = 1'b1;
    end
    next_mask = next_mask | ext_cpuq_mask;
  end

  // ----------------------------------------------------------------
  // per-frame result register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_valid <= 1'b0;
      res <= '0;
    end
    else
    begin
      res_valid <= fr_valid;
      if (fr_valid)
      begin
        res.tag <= next_tag;
        res.pop_cnt <= next_pop;
        res.aggr <= next_aggr;
        res.cpuq_mask <= next_mask;
        res.redirect <= next_redir;
        res.discard <= next_discard;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lfsr <= LFSR_SEED;
      frame_count <= 16'h0000;
    end
    else
    begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      if (fr_valid)
        frame_count <= frame_count + 16'h0001;
    end
  end

endmodule

// ===== bench/ibc_parser_model.sv
/*
  ibc_parser_model: frame parser stand-in.
  assumes: send is driven just after an edge.
*/
`timescale 1ns/1ps
module ibc_parser_model
  import ibc_pkg::*;
(
  // clock
  input wire logic aclk,
  // request from bench
  input wire logic send,
  input wire ibc_frame_t frame,
  // parsed frame out
  output logic fr_valid,
  output ibc_frame_t fr_info
);
  ibc_frame_t held;

  // ----------------------------------------------------------------
  // fields are only meaningful with fr_valid; otherwise they toggle
  // ----------------------------------------------------------------
  assign fr_valid = send;
  assign fr_info = send ? frame : ~held;

  always_ff @(posedge aclk)
    held <= fr_info;
endmodule

// ===== bench/ibc_classifier_monitor.sv
/*
  ibc_classifier_monitor: port-level checks of the classifier.
  assumes: bound into ibc_classifier, one aclk domain.
*/
`timescale 1ns/1ps
module ibc_classifier_monitor
  import ibc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // frame side
  input wire logic fr_valid,
  input wire ibc_frame_t fr_info,
  input wire logic [7:0] ext_cpuq_mask,
  input wire logic res_valid,
  input wire ibc_result_t res,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // frame path
  // ----------------------------------------------------------------
  sequence s_take;
    fr_valid;
  endsequence
  sequence s_answer;
    ##1 res_valid;
  endsequence

  a_res_next: assert property (s_take |-> s_answer)
    else $error("no result one cycle after frame");
  a_res_cause: assert property (res_valid |-> $past(fr_valid))
    else $error("result without frame");
  a_pop_clamp: assert property (
    res_valid |-> res.pop_cnt <= $past(fr_info.tag_cnt))
    else $error("pop count above tags present");
  a_prio_vid: assert property (
    res_valid && res.tag.prio_tag |-> res.tag.vid == 12'h000)
    else $error("priority tag with nonzero vid");
  a_ext_mask: assert property (res_valid |->
    (res.cpuq_mask & $past(ext_cpuq_mask)) == $past(ext_cpuq_mask))
    else $error("external cpu events lost");
  a_redir_queue: assert property (
    res_valid && res.redirect |-> res.cpuq_mask != 8'h00)
    else $error("redirect with no cpu queue");
  a_res_hold: assert property (!res_valid |-> $stable(res))
    else $error("result changed between frames");

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
endmodule

bind ibc_classifier ibc_classifier_monitor u_mon (.aclk, .aresetn,
  .fr_valid, .fr_info, .ext_cpuq_mask, .res_valid, .res, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ===== bench/tb.sv
/*
  tb: self-checking bench for ibc_classifier.
  assumes: results arrive one cycle after each frame, in order.
*/
`timescale 1ns/1ps
module tb
  import ibc_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic arvalid = 1'b0, snd = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_mask = 8'h00;
  logic [31:0] wdata = 32'h0;
  ibc_frame_t frm = '0;
  logic awready, wready, bvalid, arready, rvalid, fr_valid, res_valid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  ibc_frame_t fr_info, f;
  ibc_result_t res;
  ibc_result_t exp_q[$];
  int miscompares = 0;
  int total_checks = 0;
  logic [15:0] lfsr = 16'h002a;
  logic [31:0] pvc = RST_PORT_VLAN;
  logic [15:0] cust = 16'h0000;
  logic qpcp = 1'b0;
  logic [1:0] agg = 2'b00;

  always #4 aclk = ~aclk;

  ibc_parser_model parser (.aclk, .send(snd), .frame(frm), .fr_valid,
    .fr_info);

  ibc_classifier dut (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .fr_valid, .fr_info,
    .ext_cpuq_mask(ext_mask), .res_valid, .res);

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int n = 0;
    snd <= 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    chk(n < 40 && bresp === er, "write response");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rr);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    v = rdata;
    rr = rresp;
    if (n >= 40) miscompares++;
  endtask

  function automatic ibc_frame_t rfrm();
    ibc_frame_t g;
    g = '0;
    g.dmac = {32'h02a0_b0c0, rnd()};
    g.smac = {32'h0200_0000, rnd()};
    g.tci0 = rnd();
    g.tci1 = rnd();
    g.qos = g.smac[14:12];
    g.etype = 16'h9000;
    return g;
  endfunction

  function automatic ibc_result_t expect_res(ibc_frame_t g,
      logic [7:0] em, logic [7:0] cq, logic rd_exp);
    ibc_result_t e;
    logic [15:0] tp, tc;
    e = '0;
    {tp, tc} = pvc[PVC_INNER] && g.tag_cnt >= 2 ? {g.tpid1, g.tci1}
      : {g.tpid0, g.tci0};
    if (g.tag_cnt != 0 && (tp == TPID_CTAG || tp == TPID_STAG
        || tp == cust))
      e.tag = {tp != TPID_CTAG, tc, tc[11:0] == 12'h000};
    else
      e.tag = {pvc[PVC_TYPE], pvc[15:0], 1'b0};
    if (qpcp) e.tag.pcp = g.qos;
    e.pop_cnt = pvc[19:18] > g.tag_cnt ? g.tag_cnt : pvc[19:18];
    if (agg[0]) e.aggr ^= g.dmac[3:0] ^ g.dmac[7:4] ^ g.dmac[11:8];
    if (agg[1]) e.aggr ^= g.smac[3:0] ^ g.smac[7:4] ^ g.smac[11:8];
    e.cpuq_mask = em | cq;
    e.redirect = rd_exp;
    return e;
  endfunction

  // one frame per call; calls may follow back to back
  task automatic send(input ibc_frame_t g, input logic [7:0] cq,
                      input logic rd_exp);
    logic [15:0] x;
    x = rnd();
    exp_q.push_back(expect_res(g, x[7:0], cq, rd_exp));
    frm <= g;
    ext_mask <= x[7:0];
    snd <= 1'b1;
    @(posedge aclk);
  endtask

  always @(posedge aclk)
  begin
    if (res_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(1'b0, "result without frame");
      else
        chk(res === exp_q.pop_front(), "result differs");
    end
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    stop_test();
  end

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_PORT_VLAN, d, r);
    chk(d === RST_PORT_VLAN && r === 2'b00, "vlan reset value");
    rd(8'h3c, d, r);
    chk(r === 2'b10, "unmapped read");
    wr(8'h3c, 32'h1, 2'b10);
    f = rfrm();
    send(f, 8'h00, 1'b0);
    f.tag_cnt = 2'd1;
    f.tpid0 = TPID_CTAG;
    send(f, 8'h00, 1'b0);
    f.tpid0 = TPID_STAG;
    f.tci0[11:0] = 12'h000;
    send(f, 8'h00, 1'b0);
    f.tpid0 = 16'h9100;
    send(f, 8'h00, 1'b0);
    wr(REG_CUSTOM_TPID, 32'h9100, 2'b00);
    cust = 16'h9100;
    send(f, 8'h00, 1'b0);
    wr(REG_PORT_VLAN, 32'h000f_c005, 2'b00);
    pvc = 32'h000f_c005;
    rd(REG_PORT_VLAN, d, r);
    chk(d === pvc, "vlan config readback");
    for (int i = 0; i < 4; i++)
    begin
      f = rfrm();
      f.tag_cnt = i[1:0];
      f.tpid0 = TPID_STAG;
      f.tpid1 = TPID_CTAG;
      send(f, 8'h00, 1'b0);
    end
    wr(REG_PORT_TIMING, 32'h1, 2'b00);
    qpcp = 1'b1;
    send(rfrm(), 8'h00, 1'b0);
    for (int i = 1; i < 4; i++)
    begin
      wr(REG_AGGR_SRC, i, 2'b00);
      agg = i[1:0];
      send(rfrm(), 8'h00, 1'b0);
    end
    // igmp to queue 3, ipmc to queue 1, register access to queue 5
    wr(REG_CPUQ, 32'h0000_0a43, 2'b00);
    wr(REG_CPU_FWD, 32'h0000_0025, 2'b00);
    wr(REG_RAF_VALUE, 32'h1234_5678, 2'b00);
    wr(REG_RAF_MASK, 32'h0000_00ff, 2'b00);
    f = rfrm();
    f.dmac = 48'h0100_5e00_0001;
    f.etype = ETYPE_IPV4;
    f.ip_proto = IP_PROTO_IGMP;
    send(f, 8'h08, 1'b1);
    f.ip_proto = 8'h11;
    f.dip = 32'he000_0005;
    send(f, 8'h02, 1'b0);
    f = rfrm();
    f.etype = ETYPE_RAF;
    f.proto_id = RAF_PROTO_ID;
    f.raf_hdr = 32'h1234_56aa;
    send(f, 8'h20, 1'b1);
    f.raf_hdr = 32'h0234_56aa;
    send(f, 8'h00, 1'b0);
    f.raf_hdr = 32'h1234_5600;
    f.proto_id = 16'h0005;
    send(f, 8'h00, 1'b0);
    f.proto_id = RAF_PROTO_ID;
    f.tag_cnt = 2'd1;
    f.tpid0 = 16'h1234;
    send(f, 8'h00, 1'b0);
    snd <= 1'b0;
    repeat (4) @(posedge aclk);
    stop_test();
  end
endmodule
